//--- bench/nfsr_nand_model.sv
// nand device model driving the wait/ready pins
// assumes the bench commands busy per device; a busy device holds its pin low
`timescale 1ns/1ns
module nfsr_nand_model (
	input wire aclk,
	input wire [1:0] busy,
	output logic [1:0] ext_wait_input = 2'h0
);
	// pins change only after a clock edge, as a registered ready output would
	always @(posedge aclk) begin
		ext_wait_input <= ~busy;
	end
endmodule

//--- bench/nfsr_top_assertions.sv
// bus and reset checks for the nand status block, bound to nfsr_top
// assumes one clock aclk, synchronous active-low reset and ce high while the bus is busy
`timescale 1ns/1ns
module nfsr_chk (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	property p_rd_ans;
		s_ar |=> s_axi_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
	property p_rd_hold;
		s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
	property p_rsvd;
		s_axi_rvalid |-> s_axi_rdata[31:18] == 14'h0 && s_axi_rdata[15:12] == 4'h0
			&& s_axi_rdata[7:4] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	sequence s_ar_stat;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h000;
	endsequence
	property p_state_rsvd;
		s_ar_stat |=> s_axi_rdata[11:8] != 4'h4
			&& (s_axi_rdata[11:8] < 4'h9 || s_axi_rdata[11:8] > 4'hB);
	endproperty
	a_state_rsvd: assert property (p_state_rsvd) else $error("reserved state read");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	property p_wr_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response not held");
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write taken while busy");
	// reset itself is the cause here, so the default disable is overridden
	property p_rst;
		disable iff (1'b0) !aresetn |=> !s_axi_rvalid && !s_axi_bvalid && !irq;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind nfsr_top nfsr_chk u_nfsr_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_araddr, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .irq);

//--- bench/tb_nfsr_top.sv
// self-checking bench for the nand status block
// assumes the nand model on the wait pins; the ecc datapath pulses come from here
`timescale 1ns/1ns
module tb_nfsr_top;
	logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
	logic s_axi_arvalid = 0, s_axi_rready = 1, ecc4_locate_start = 0, ecc_phase_done = 0;
	logic ecc_err_bit89 = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, ecc_err_total = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] busy = 2'h3, ec = 2'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp, ext_wait_input;
	wire [31:0] s_axi_rdata;
	int num_errors = 0, n_compared = 0, lag = 0;
	always #25 aclk = ~aclk;
	nfsr_top u_nfsr_top (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ext_wait_input, .ecc4_locate_start, .ecc_phase_done,
		.ecc_err_total, .ecc_err_bit89, .irq);
	nfsr_nand_model u_nfsr_nand_model (.aclk, .busy, .ext_wait_input);
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		chk(nm, {30'h0, e}, {30'h0, g});
	endtask
	task chk_irq(input logic e);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	// lag > 0 raises bready or rready late, so the answer must stand meanwhile
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= (lag == 0);
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		if (lag != 0) begin
			repeat (lag - 1) @(posedge aclk);
			s_axi_bready <= 1;
			@(posedge aclk);
		end
		chk_resp("bresp", er, s_axi_bresp);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= (lag == 0);
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		if (lag != 0) begin
			repeat (lag - 1) @(posedge aclk);
			s_axi_rready <= 1;
			@(posedge aclk);
		end
		chk("rdata", e, s_axi_rdata);
		chk_resp("rresp", er, s_axi_rresp);
	endtask
	task pulse(input logic s, input logic [2:0] t, input logic b);
		@(posedge aclk);
		ecc4_locate_start <= s;
		ecc_phase_done <= !s;
		ecc_err_total <= t;
		ecc_err_bit89 <= b;
		@(posedge aclk);
		ecc4_locate_start <= 0;
		ecc_phase_done <= 0;
	endtask
	// wait pins are held still during a run, so they fold into every expected word
	function logic [31:0] stv(input logic [3:0] s);
		return {14'h0, ec, 4'h0, s, 6'h0, ~busy};
	endfunction
	task run(input logic [2:0] t, input logic b);
		logic [3:0] st;
		pulse(1, 3'h0, 0);
		rd(12'h000, stv(4'h5), 2'h0);
		pulse(0, t, b);
		if (t == 3'h0 || t > 3'h4) begin
			rd(12'h000, stv(t == 3'h0 ? 4'h0 : 4'h1), 2'h0);
		end else begin
			ec = t[1:0] - 2'h1;
			st = 4'h6;
			repeat (3 + t) begin
				rd(12'h000, stv(st), 2'h0);
				st = st == 4'h8 ? 4'hC : st + 4'h1;
				pulse(0, t, b);
			end
			repeat (2) rd(12'h000, stv(b ? 4'h2 : 4'h3), 2'h0);
		end
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		num_errors++;
		print_verdict;
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rd(12'h000, 32'h0, 2'h0);
		lag = 2;
		rd(12'h008, 32'h0, 2'h0);
		wr(12'h008, 32'h3, 2'h0);
		lag = 0;
		busy <= 2'h2;
		repeat (3) @(posedge aclk);
		rd(12'h000, 32'h1, 2'h0);
		busy <= 2'h1;
		repeat (3) @(posedge aclk);
		rd(12'h000, 32'h2, 2'h0);
		rd(12'h004, 32'hC, 2'h0);
		chk_irq(0);
		wr(12'h000, 32'hFFFFFFFF, 2'h0);
		rd(12'h000, 32'h2, 2'h0);
		rd(12'h00C, 32'h0, 2'h2);
		wr(12'h00C, 32'h1, 2'h2);
		run(3'h2, 0);
		// ce low must swallow a start pulse, so the finished state stays put
		ce <= 0;
		pulse(1, 3'h0, 0);
		ce <= 1;
		rd(12'h000, stv(4'h3), 2'h0);
		run(3'h0, 0);
		run(3'h5, 0);
		run(3'h4, 1);
		run(3'h1, 0);
		chk_irq(1);
		rd(12'h004, 32'hF, 2'h0);
		wr(12'h004, 32'hF, 2'h0);
		chk_irq(0);
		rd(12'h004, 32'h0, 2'h0);
		// second reset with wait pin 1 high: no false wait edge may follow it
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		ec = 2'h0;
		rd(12'h000, stv(4'h0), 2'h0);
		rd(12'h004, 32'h0, 2'h0);
		rd(12'h008, 32'h0, 2'h0);
		chk_irq(0);
		print_verdict;
	end
endmodule

//--- hdl/nfsr_calc_seq.v
// phase sequencer of the 4-bit ecc error address and value calculation
// assumes the ecc datapath pulses phase_done at the end of each phase and
// holds err_total and err_bit89 valid while it does
`timescale 1ns/1ns
`include "nfsr_map.vh"

module nfsr_calc_seq (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire calc_start,
	input wire phase_done,
	input wire [2:0] err_total,
	input wire err_bit89,
	output reg [3:0] state_r,
	output reg [1:0] err_count_r,
	output reg done_pulse_r,
	output reg uncorr_pulse_r
);

	localparam [3:0] ST_NO_ERR = `NFSR_ST_NO_ERR;
	localparam [3:0] ST_UNCORR = `NFSR_ST_UNCORR;
	localparam [3:0] ST_DONE_B89 = `NFSR_ST_DONE_B89;
	localparam [3:0] ST_DONE_ERR = `NFSR_ST_DONE_ERR;
	localparam [3:0] ST_COUNT = `NFSR_ST_COUNT;
	localparam [3:0] ST_PREP_A = `NFSR_ST_PREP_A;
	localparam [3:0] ST_PREP_B = `NFSR_ST_PREP_B;
	localparam [3:0] ST_SEARCH = `NFSR_ST_SEARCH;
	localparam [3:0] ST_VAL0 = `NFSR_ST_VALUE;
	localparam [3:0] ST_VAL1 = 4'hD;
	localparam [3:0] ST_VAL2 = 4'hE;
	localparam [3:0] ST_VAL3 = 4'hF;

	reg [3:0] state_nxt;
	reg [1:0] err_count_nxt;
	reg b89_r;
	reg b89_nxt;
	reg done_nxt;
	reg uncorr_nxt;
	wire [3:0] last_val;

	// one value phase per located error: C for the first, up to F for the fourth
	assign last_val = ST_VAL0 + {2'h0, err_count_r};

	always @* begin
		state_nxt = state_r;
		err_count_nxt = err_count_r;
		b89_nxt = b89_r;
		done_nxt = 1'b0;
		uncorr_nxt = 1'b0;
		if (calc_start) begin
			// a new start restarts a calculation already under way
			state_nxt = ST_COUNT; // R4
			b89_nxt = 1'b0;
		end else if (phase_done) begin
			case (state_r)
			ST_COUNT: begin
				if (err_total == 3'h0) begin
					state_nxt = ST_NO_ERR; // R2
					done_nxt = 1'b1;
				end else if (err_total > 3'h4) begin
					state_nxt = ST_UNCORR; // R2
					done_nxt = 1'b1;
					uncorr_nxt = 1'b1;
				end else begin
					err_count_nxt = err_total[1:0] - 2'h1; // R1
					state_nxt = ST_PREP_A; // R4
				end
			end
			ST_PREP_A: begin
				state_nxt = ST_PREP_B; // R4
			end
			ST_PREP_B: begin
				state_nxt = ST_SEARCH; // R4
			end
			ST_SEARCH: begin
				b89_nxt = err_bit89;
				state_nxt = ST_VAL0; // R4
			end
			ST_VAL0, ST_VAL1, ST_VAL2, ST_VAL3: begin
				if (state_r == last_val) begin
					state_nxt = (b89_r | err_bit89) ? ST_DONE_B89 : ST_DONE_ERR; // R3
					done_nxt = 1'b1;
				end else begin
					state_nxt = state_r + 4'h1; // R4
				end
			end
			default: begin
				state_nxt = state_r;
			end
			endcase
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= 4'h0; // R7
			err_count_r <= 2'h0; // R7
			b89_r <= 1'b0;
			done_pulse_r <= 1'b0;
			uncorr_pulse_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt; // R9
			err_count_r <= err_count_nxt; // R9
			b89_r <= b89_nxt;
			done_pulse_r <= done_nxt;
			uncorr_pulse_r <= uncorr_nxt;
		end
	end

endmodule

//--- hdl/nfsr_map.vh
// register offsets, field positions and reset values of the nand status block
// included by the status top and the calculation sequencer
`ifndef NFSR_MAP_VH
`define NFSR_MAP_VH

`define NFSR_OFF_STATUS 12'h000
`define NFSR_OFF_INT_STATUS 12'h004
`define NFSR_OFF_INT_MASK 12'h008

`define NFSR_ERRCNT_HI 17
`define NFSR_ERRCNT_LO 16
`define NFSR_STATE_HI 11
`define NFSR_STATE_LO 8
`define NFSR_WAIT_HI 1
`define NFSR_WAIT_LO 0

`define NFSR_ST_NO_ERR 4'h0
`define NFSR_ST_UNCORR 4'h1
`define NFSR_ST_DONE_B89 4'h2
`define NFSR_ST_DONE_ERR 4'h3
`define NFSR_ST_COUNT 4'h5
`define NFSR_ST_PREP_A 4'h6
`define NFSR_ST_PREP_B 4'h7
`define NFSR_ST_SEARCH 4'h8
`define NFSR_ST_VALUE 4'hC

`define NFSR_INT_DONE 0
`define NFSR_INT_UNCORR 1
`define NFSR_INT_WAIT0 2
`define NFSR_INT_WAIT1 3
`define NFSR_INT_W 4

`define NFSR_RST_STATUS 32'h00000000
`define NFSR_RST_INT 4'h0

`define NFSR_RESP_OKAY 2'h0
`define NFSR_RESP_SLVERR 2'h2

`endif

//--- hdl/nfsr_top.v
// nand flash status register with ecc progress, wait pins and interrupts
// assumes an axi4-lite master on aclk and wait pins already synchronous to aclk
//
// Contract
// (R1) The two-bit error count field shows the number of located errors minus one.
// (R2) The state field reads zero for no errors and one for five or more errors.
// (R3) A correctable finish reads two with errors on bit 8 or 9 and three otherwise.
// (R4) While running the state shows 5 counting, 6 and 7 preparing, 8 searching, C-F values.
// (R5) Each wait status bit shows the raw level of its own external wait pin.
// (R6) The wait polarity configuration has no effect on the wait status bits.
// (R7) The status register is read-only, resets to zero and reads reserved bits as zero.
// (R8) Software starts the calculation through a start bit held in the nand control register.
// (R9) Reading the status has no side effect and its fields follow the engine live.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "nfsr_map.vh"

module nfsr_top #(
	parameter [1:0] WAIT_PRESENT = 2'h3
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [11:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [1:0] ext_wait_input,
	input wire ecc4_locate_start,
	input wire ecc_phase_done,
	input wire [2:0] ecc_err_total,
	input wire ecc_err_bit89,
	output wire irq
);

	localparam [11:0] OFF_STATUS = `NFSR_OFF_STATUS;
	localparam [11:0] OFF_INT_STATUS = `NFSR_OFF_INT_STATUS;
	localparam [11:0] OFF_INT_MASK = `NFSR_OFF_INT_MASK;
	localparam [1:0] RESP_OKAY = `NFSR_RESP_OKAY;
	localparam [1:0] RESP_SLVERR = `NFSR_RESP_SLVERR;

	wire [3:0] ecc_state;
	wire [1:0] ecc_error_count;
	wire calc_done;
	wire calc_uncorr;

	reg [1:0] wait_pin_status_r;
	reg [1:0] wait_prev_r;
	reg wait_primed_r;
	reg [`NFSR_INT_W-1:0] int_status_r;
	reg [`NFSR_INT_W-1:0] int_status_nxt;
	reg [`NFSR_INT_W-1:0] int_mask_r;
	reg [`NFSR_INT_W-1:0] int_event;
	reg [31:0] nand_flash_status;

	reg aw_held_r;
	reg [11:0] aw_addr_r;
	reg w_held_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	wire wr_go;
	wire [11:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire wr_int_status;
	wire wr_int_mask;
	wire wr_mapped;
	reg [31:0] rd_data;
	reg rd_mapped;

	// the start bit itself lives in the nand control register; only its pulse arrives here
	nfsr_calc_seq u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.calc_start(ecc4_locate_start), // R8
		.phase_done(ecc_phase_done),
		.err_total(ecc_err_total),
		.err_bit89(ecc_err_bit89),
		.state_r(ecc_state),
		.err_count_r(ecc_error_count),
		.done_pulse_r(calc_done),
		.uncorr_pulse_r(calc_uncorr)
	);

	// wait pins: one register stage only, no polarity inversion applied
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_wait
			always @(posedge aclk) begin
				if (!aresetn) begin
					wait_pin_status_r[gi] <= 1'b0; // R7
					wait_prev_r[gi] <= 1'b0;
				end else if (ce) begin
					// an absent pin reads constant zero
					wait_pin_status_r[gi] <= ext_wait_input[gi] & WAIT_PRESENT[gi]; // R5 R6
					// first cycle out of reset copies the pin, so a pin idling high is no edge
					wait_prev_r[gi] <= wait_primed_r ? wait_pin_status_r[gi] :
						(ext_wait_input[gi] & WAIT_PRESENT[gi]);
				end
			end
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			wait_primed_r <= 1'b0;
		end else if (ce) begin
			wait_primed_r <= 1'b1;
		end
	end

	always @* begin
		nand_flash_status = `NFSR_RST_STATUS; // R7
		nand_flash_status[`NFSR_ERRCNT_HI:`NFSR_ERRCNT_LO] = ecc_error_count; // R1 R9
		nand_flash_status[`NFSR_STATE_HI:`NFSR_STATE_LO] = ecc_state; // R9
		nand_flash_status[`NFSR_WAIT_HI:`NFSR_WAIT_LO] = wait_pin_status_r; // R5
	end

	// write channel: address and data are taken in either order, one write at a time
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
	assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
	assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
	assign wr_go = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
		(w_held_r || (s_axi_wvalid && s_axi_wready));
	assign wr_mapped = (wr_addr[11:2] == OFF_STATUS[11:2]) ||
		(wr_addr[11:2] == OFF_INT_STATUS[11:2]) ||
		(wr_addr[11:2] == OFF_INT_MASK[11:2]);
	assign wr_int_status = wr_go && (wr_addr[11:2] == OFF_INT_STATUS[11:2]) && wr_strb[0];
	assign wr_int_mask = wr_go && (wr_addr[11:2] == OFF_INT_MASK[11:2]) && wr_strb[0];

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_held_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// writes to the status word are dropped quietly since it is read-only
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR; // R7
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_r <= 1'b1;
					aw_addr_r <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_r <= 1'b1;
					w_data_r <= s_axi_wdata;
					w_strb_r <= s_axi_wstrb;
				end
				if (s_axi_bvalid && s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// read channel: one read at a time, answered the cycle after the address
	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		rd_data = 32'h00000000;
		rd_mapped = 1'b1;
		case (s_axi_araddr[11:2])
		OFF_STATUS[11:2]: begin
			rd_data = nand_flash_status; // R9
		end
		OFF_INT_STATUS[11:2]: begin
			rd_data[`NFSR_INT_W-1:0] = int_status_r;
		end
		OFF_INT_MASK[11:2]: begin
			rd_data[`NFSR_INT_W-1:0] = int_mask_r;
		end
		default: begin
			rd_mapped = 1'b0;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// interrupt events: a new event in the clearing cycle survives the clear
	always @* begin
		int_event = {`NFSR_INT_W{1'b0}};
		int_event[`NFSR_INT_DONE] = calc_done;
		int_event[`NFSR_INT_UNCORR] = calc_uncorr;
		int_event[`NFSR_INT_WAIT0] = wait_pin_status_r[0] & ~wait_prev_r[0];
		int_event[`NFSR_INT_WAIT1] = wait_pin_status_r[1] & ~wait_prev_r[1];
		int_status_nxt = int_status_r;
		if (wr_int_status) begin
			int_status_nxt = int_status_r & ~wr_data[`NFSR_INT_W-1:0];
		end
		int_status_nxt = int_status_nxt | int_event;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			int_status_r <= `NFSR_RST_INT;
			int_mask_r <= `NFSR_RST_INT;
		end else if (ce) begin
			int_status_r <= int_status_nxt;
			if (wr_int_mask) begin
				int_mask_r <= wr_data[`NFSR_INT_W-1:0];
			end
		end
	end

	assign irq = |(int_status_r & int_mask_r);

endmodule
